// >>> core/ucm_channel_ctrl.sv
// Purpose: two-channel mode, clock select, command and status registers with holding registers
// Assumes: host strobes are one cycle wide and synchronous to i_clock
// Notes:   read data appears on o_rdata one cycle after the read strobe
`timescale 1ns/100ps
module ucm_channel_ctrl #(
    parameter int CHANNELS = ucm_pkg::CHANNELS
) (
    // clock and reset
    input  wire logic                                   i_clock,
    input  wire logic                                   i_rstn,
    // host register port
    input  wire logic [3:0]                             i_addr,
    input  wire logic                                   i_read_strobe,
    input  wire logic                                   i_write_strobe,
    input  wire logic [7:0]                             i_wdata,
    output logic      [7:0]                             o_rdata,
    // line side receive
    input  wire logic [CHANNELS-1:0]                    i_rx_char_valid,
    input  ucm_pkg::ucm_rx_char_type [CHANNELS-1:0]     i_rx_char,
    // line side transmit
    input  wire logic [CHANNELS-1:0]                    i_tx_char_taken,
    input  wire logic [CHANNELS-1:0]                    i_tx_idle,
    output logic      [CHANNELS-1:0]                    o_tx_char_valid,
    output ucm_pkg::ucm_tx_char_type [CHANNELS-1:0]     o_tx_char,
    // configuration and status
    output ucm_pkg::ucm_cfg_type [CHANNELS-1:0]         o_cfg,
    output logic      [CHANNELS-1:0]                    o_receive_irq_source,
    output logic      [CHANNELS-1:0]                    o_receiver_char_available,
    output logic      [CHANNELS-1:0]                    o_receive_buffer_full,
    output logic      [CHANNELS-1:0]                    o_transmitter_can_accept,
    output logic      [CHANNELS-1:0]                    o_transmitter_drained
);
    if (CHANNELS < 1 || CHANNELS > 2) begin : g_bad_channels
        $error("CHANNELS must be 1 or 2");
    end

    logic [CHANNELS-1:0][7:0]           mr1_q;
    logic [CHANNELS-1:0][7:0]           mr2_q;
    logic [CHANNELS-1:0][7:0]           csel_q;
    ucm_pkg::ucm_mr_ptr_type [CHANNELS-1:0] ptr_q;
    logic [CHANNELS-1:0]                rx_en_q;
    logic [CHANNELS-1:0]                tx_en_q;
    ucm_pkg::ucm_rx_char_type [CHANNELS-1:0] rhr_q;
    logic [CHANNELS-1:0]                rx_full_q;
    logic [CHANNELS-1:0]                overrun_q;
    logic [CHANNELS-1:0][2:0]           blk_q;
    ucm_pkg::ucm_tx_char_type [CHANNELS-1:0] thr_q;
    logic [CHANNELS-1:0]                thr_full_q;
    logic [7:0]                         rdata_q;

    logic [CHANNELS-1:0]                chan_hit;
    logic [CHANNELS-1:0]                wr_mode;
    logic [CHANNELS-1:0]                wr_csel;
    logic [CHANNELS-1:0]                wr_cmd;
    logic [CHANNELS-1:0]                wr_hold;
    logic [CHANNELS-1:0]                rd_mode;
    logic [CHANNELS-1:0]                rd_hold;
    logic [CHANNELS-1:0]                rx_reset;
    logic [CHANNELS-1:0]                tx_reset;
    logic [CHANNELS-1:0]                err_reset;
    logic [CHANNELS-1:0]                ptr_reset;
    logic [CHANNELS-1:0]                multidrop;
    logic [CHANNELS-1:0]                rx_accept;
    logic [CHANNELS-1:0]                rx_store;
    logic [CHANNELS-1:0]                rx_overrun;
    logic [CHANNELS-1:0]                thr_load;
    logic [CHANNELS-1:0][2:0]           new_err;
    logic [CHANNELS-1:0][7:0]           status;
    logic [CHANNELS-1:0][7:0]           mode_rd;
    logic [CHANNELS-1:0][7:0]           chan_rd;
    logic [3:0]                         misc_cmd;
    logic [7:0]                         rd_value;
    logic                               rd_chan;

    assign misc_cmd = i_wdata[7:4];
    assign rd_chan  = i_addr[ucm_pkg::ADDR_CHAN_BIT];

    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_dec
        assign chan_hit[ch]  = (i_addr[ucm_pkg::ADDR_CHAN_BIT] == 1'(ch)) && (i_addr[2] == 1'b0);
        assign wr_mode[ch]   = i_write_strobe && chan_hit[ch] && i_addr[2:0] == ucm_pkg::OFF_MODE;
        assign wr_csel[ch]   = i_write_strobe && chan_hit[ch] && i_addr[2:0] == ucm_pkg::OFF_STAT;
        assign wr_cmd[ch]    = i_write_strobe && chan_hit[ch] && i_addr[2:0] == ucm_pkg::OFF_CMD;
        assign wr_hold[ch]   = i_write_strobe && chan_hit[ch] && i_addr[2:0] == ucm_pkg::OFF_HOLD;
        assign rd_mode[ch]   = i_read_strobe && chan_hit[ch] && i_addr[2:0] == ucm_pkg::OFF_MODE;
        assign rd_hold[ch]   = i_read_strobe && chan_hit[ch] && i_addr[2:0] == ucm_pkg::OFF_HOLD;
        // miscellaneous commands act on the write itself; spacing is the host's concern
        assign ptr_reset[ch] = wr_cmd[ch] && misc_cmd == ucm_pkg::CMD_RESET_PTR;
        assign rx_reset[ch]  = wr_cmd[ch] && misc_cmd == ucm_pkg::CMD_RESET_RX;
        assign tx_reset[ch]  = wr_cmd[ch] && misc_cmd == ucm_pkg::CMD_RESET_TX;
        assign err_reset[ch] = wr_cmd[ch] && misc_cmd == ucm_pkg::CMD_RESET_ERR;
        assign multidrop[ch] = mr1_q[ch][4:3] == ucm_pkg::PAR_MULTIDROP;
        // disabled multidrop receiver still keeps address-tagged characters
        assign rx_accept[ch] = i_rx_char_valid[ch] && !rx_reset[ch]
                               && (rx_en_q[ch] || (multidrop[ch] && i_rx_char[ch].tag_or_perr));
        assign rx_store[ch]  = rx_accept[ch] && (!rx_full_q[ch] || rd_hold[ch]);
        assign rx_overrun[ch] = rx_accept[ch] && rx_full_q[ch] && !rd_hold[ch];
        assign new_err[ch]   = {i_rx_char[ch].brk, i_rx_char[ch].frame_err, i_rx_char[ch].tag_or_perr};
        assign thr_load[ch]  = wr_hold[ch] && tx_en_q[ch] && !thr_full_q[ch];
        assign status[ch][7:5] = mr1_q[ch][ucm_pkg::MR1_ERRMODE_BIT] ? blk_q[ch]
                                 : (rx_full_q[ch] ? {rhr_q[ch].brk, rhr_q[ch].frame_err,
                                                     rhr_q[ch].tag_or_perr} : 3'h0);
        assign status[ch][4] = overrun_q[ch];
        assign status[ch][3] = o_transmitter_drained[ch];
        assign status[ch][2] = o_transmitter_can_accept[ch];
        assign status[ch][1] = o_receive_buffer_full[ch];
        assign status[ch][0] = o_receiver_char_available[ch];
        assign mode_rd[ch]   = (ptr_q[ch] == ucm_pkg::UCM_MR_ONE) ? mr1_q[ch] : mr2_q[ch];
        assign chan_rd[ch]   = (i_addr[2:0] == ucm_pkg::OFF_MODE) ? mode_rd[ch]
                             : (i_addr[2:0] == ucm_pkg::OFF_STAT) ? status[ch]
                             : (i_addr[2:0] == ucm_pkg::OFF_HOLD) ? rhr_q[ch].data : 8'h00;

        assign o_receiver_char_available[ch] = rx_full_q[ch];
        assign o_receive_buffer_full[ch]     = rx_full_q[ch];
        assign o_receive_irq_source[ch]      = mr1_q[ch][ucm_pkg::MR1_IRQSRC_BIT]
                                               ? o_receive_buffer_full[ch]
                                               : o_receiver_char_available[ch];
        assign o_transmitter_can_accept[ch]  = tx_en_q[ch] && !thr_full_q[ch];
        assign o_transmitter_drained[ch]     = tx_en_q[ch] && !thr_full_q[ch] && i_tx_idle[ch];
        assign o_tx_char_valid[ch]           = thr_full_q[ch];
        assign o_tx_char[ch]                 = thr_q[ch];

        assign o_cfg[ch].rx_flow_ctrl    = mr1_q[ch][ucm_pkg::MR1_RTS_BIT];
        assign o_cfg[ch].irq_src_full    = mr1_q[ch][ucm_pkg::MR1_IRQSRC_BIT];
        assign o_cfg[ch].block_err       = mr1_q[ch][ucm_pkg::MR1_ERRMODE_BIT];
        assign o_cfg[ch].parity_mode     = mr1_q[ch][4:3];
        assign o_cfg[ch].parity_odd      = mr1_q[ch][ucm_pkg::MR1_PTYPE_BIT];
        assign o_cfg[ch].data_bits       = ucm_pkg::BITS_BASE + {2'h0, mr1_q[ch][1:0]};
        assign o_cfg[ch].chan_mode       = mr2_q[ch][7:6];
        assign o_cfg[ch].tx_flow_ctrl    = mr2_q[ch][ucm_pkg::MR2_TRANSMITTER_FLOW_REQUEST_CONTROL_BIT];
        assign o_cfg[ch].cts_enable      = mr2_q[ch][ucm_pkg::MR2_CTS_BIT];
        assign o_cfg[ch].stop_sixteenths = ucm_pkg::stop_len(mr2_q[ch][3:0], mr1_q[ch][1:0]);
        assign o_cfg[ch].rx_clk_sel      = csel_q[ch][7:4];
        assign o_cfg[ch].tx_clk_sel      = csel_q[ch][3:0];
        assign o_cfg[ch].rx_enabled      = rx_en_q[ch];
        assign o_cfg[ch].tx_enabled      = tx_en_q[ch];
    end

    assign rd_value = (32'(rd_chan) < CHANNELS) ? chan_rd[rd_chan] : 8'h00;
    assign o_rdata  = rdata_q;

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            mr1_q      <= '0;
            mr2_q      <= '0;
            csel_q     <= '0;
            for (int ch = 0; ch < CHANNELS; ch++) begin
                ptr_q[ch] <= ucm_pkg::UCM_MR_ONE;
            end
            rx_en_q    <= '0;
            tx_en_q    <= '0;
            rhr_q      <= '0;
            rx_full_q  <= '0;
            overrun_q  <= '0;
            blk_q      <= '0;
            thr_q      <= '0;
            thr_full_q <= '0;
            rdata_q    <= ucm_pkg::REG_RESET;
        end else begin
            if (i_read_strobe) begin
                rdata_q <= rd_value;
            end
            for (int ch = 0; ch < CHANNELS; ch++) begin
                if (wr_mode[ch] && ptr_q[ch] == ucm_pkg::UCM_MR_ONE) begin
                    mr1_q[ch] <= i_wdata;
                end
                if (wr_mode[ch] && ptr_q[ch] == ucm_pkg::UCM_MR_TWO) begin
                    mr2_q[ch] <= i_wdata;
                end
                if (ptr_reset[ch]) begin
                    ptr_q[ch] <= ucm_pkg::UCM_MR_ONE;
                end else if (wr_mode[ch] || rd_mode[ch]) begin
                    ptr_q[ch] <= ucm_pkg::UCM_MR_TWO;
                end
                if (wr_csel[ch]) begin
                    csel_q[ch] <= i_wdata;
                end
                if (rx_reset[ch] || (wr_cmd[ch] && i_wdata[ucm_pkg::CR_RX_DIS])) begin
                    rx_en_q[ch] <= 1'b0;
                end else if (wr_cmd[ch] && i_wdata[ucm_pkg::CR_RX_EN]) begin
                    rx_en_q[ch] <= 1'b1;
                end
                if (tx_reset[ch] || (wr_cmd[ch] && i_wdata[ucm_pkg::CR_TX_DIS])) begin
                    tx_en_q[ch] <= 1'b0;
                end else if (wr_cmd[ch] && i_wdata[ucm_pkg::CR_TX_EN]) begin
                    tx_en_q[ch] <= 1'b1;
                end
                // receive holding register; a new char wins over the read that empties it
                if (rx_store[ch]) begin
                    rhr_q[ch]     <= i_rx_char[ch];
                    rx_full_q[ch] <= 1'b1;
                end else if (rd_hold[ch] || rx_reset[ch]) begin
                    rx_full_q[ch] <= 1'b0;
                end
                if (rx_overrun[ch]) begin
                    overrun_q[ch] <= 1'b1;
                end else if (err_reset[ch] || rx_reset[ch]) begin
                    overrun_q[ch] <= 1'b0;
                end
                // accumulated errors; a new error wins over the clearing command
                if (err_reset[ch] || rx_reset[ch]) begin
                    blk_q[ch] <= rx_store[ch] ? new_err[ch] : 3'h0;
                end else if (rx_store[ch]) begin
                    blk_q[ch] <= blk_q[ch] | new_err[ch];
                end
                if (thr_load[ch]) begin
                    thr_q[ch].data     <= i_wdata;
                    thr_q[ch].tag      <= mr1_q[ch][ucm_pkg::MR1_PTYPE_BIT];
                    thr_q[ch].tag_used <= multidrop[ch];
                    thr_full_q[ch]     <= 1'b1;
                end else if (i_tx_char_taken[ch] || tx_reset[ch]) begin
                    thr_full_q[ch] <= 1'b0;
                end
            end
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chk
        a_thr_refused: assert property (wr_hold[ch] && !tx_en_q[ch] && !thr_full_q[ch] |=> !thr_full_q[ch])
            else $error("holding register loaded while transmitter disabled");
        a_irq_full_pick: assert property (mr1_q[ch][6] && !rx_full_q[ch] |-> !o_receive_irq_source[ch])
            else $error("receive irq source wrong");
        a_block_err_hold: assert property (mr1_q[ch][5] && !err_reset[ch] && !rx_reset[ch]
                                           |=> (blk_q[ch] & $past(blk_q[ch])) == $past(blk_q[ch]))
            else $error("block error lost without reset");
        a_char_err_view: assert property (!mr1_q[ch][5] && rx_full_q[ch]
                                          |-> status[ch][5] == rhr_q[ch].tag_or_perr)
            else $error("character mode status not from held char");
        a_block_err_view: assert property (mr1_q[ch][5] |-> status[ch][7:5] == blk_q[ch])
            else $error("block mode status not accumulated");
        a_stop_five_bit: assert property (mr1_q[ch][1:0] == 2'h0 && mr2_q[ch][3] == 1'b0
                                          |-> o_cfg[ch].stop_sixteenths == 6'h11 + {3'h0, mr2_q[ch][2:0]})
            else $error("five bit stop extension wrong");
        a_stop_table: assert property (mr1_q[ch][1:0] == 2'h3 && mr2_q[ch][3:0] == 4'h7
                                       |-> o_cfg[ch].stop_sixteenths == 6'h10)
            else $error("stop length code 7 not one bit");
        a_stop_long_max: assert property (mr2_q[ch][3:0] == 4'hf |-> o_cfg[ch].stop_sixteenths == 6'h20)
            else $error("stop length code F not two bits");
        a_multidrop_tag: assert property (thr_load[ch] && multidrop[ch]
                                          |=> o_tx_char[ch].tag_used && o_tx_char[ch].tag == $past(mr1_q[ch][2]))
            else $error("multidrop tag not taken from parity type");
        a_drop_data_tag: assert property (i_rx_char_valid[ch] && !rx_en_q[ch] && multidrop[ch]
                                          && !i_rx_char[ch].tag_or_perr && !rx_full_q[ch] |=> !rx_full_q[ch])
            else $error("data tagged char kept by disabled receiver");
        a_addr_wakes: assert property (i_rx_char_valid[ch] && multidrop[ch] && i_rx_char[ch].tag_or_perr
                                       && !rx_full_q[ch] && !rx_reset[ch] |=> rx_full_q[ch] && rhr_q[ch].tag_or_perr)
            else $error("address char did not wake receiver");
        a_clock_split: assert property (wr_csel[ch] |=> o_cfg[ch].rx_clk_sel == $past(i_wdata[7:4])
                                        && o_cfg[ch].tx_clk_sel == $past(i_wdata[3:0]))
            else $error("clock select nibbles swapped");
        a_mode_two_write: assert property (wr_mode[ch] && ptr_q[ch] == ucm_pkg::UCM_MR_TWO
                                           |=> o_cfg[ch].chan_mode == $past(i_wdata[7:6]))
            else $error("channel mode not stored");
        a_parity_write: assert property (wr_mode[ch] && ptr_q[ch] == ucm_pkg::UCM_MR_ONE
                                         |=> o_cfg[ch].parity_mode == $past(i_wdata[4:3])
                                         && o_cfg[ch].data_bits == 4'h5 + {2'h0, $past(i_wdata[1:0])})
            else $error("mode one fields not stored");
    end
endmodule

// >>> core/ucm_pkg.sv
// Purpose: constants, field layout and carriers for the per-channel mode, command and status logic
// Assumes: host register port with 4-bit address, 8-bit data, one-cycle read and write strobes
// Notes:   address bit 3 picks the channel, bits 2:0 pick the register within it
// How it works
// - mode one bit 6 picks receive irq source: char available or buffer full
// - mode one bit 5 picks per-character or accumulated block error status
// - block errors stay set until error-reset command 4x or receiver reset
// - mode one bits 4:3 parity mode, bit 2 even or odd parity type
// - mode two bits 7:6: normal, echo, local loop, remote loop
// - five-bit characters add half a bit of stop for codes 0 to 7
// - disabled transmitter refuses writes to the transmit holding register
// - multidrop sends parity-type bit as tag: one address, zero data
// - multidrop: disabled receiver keeps address chars, drops data chars, tag in parity slot
package ucm_pkg;
    localparam int CHANNELS      = 2;
    localparam int ADDR_CHAN_BIT = 3;
    // register offsets inside a channel
    localparam logic [2:0] OFF_MODE   = 3'h0;
    localparam logic [2:0] OFF_STAT   = 3'h1;
    localparam logic [2:0] OFF_CMD    = 3'h2;
    localparam logic [2:0] OFF_HOLD   = 3'h3;
    localparam logic [7:0] REG_RESET  = 8'h00;
    // mode one fields
    localparam int MR1_IRQSRC_BIT = 6;
    localparam int MR1_ERRMODE_BIT = 5;
    localparam int MR1_RTS_BIT    = 7;
    localparam int MR1_PTYPE_BIT  = 2;
    // mode two fields
    localparam int MR2_TRANSMITTER_FLOW_REQUEST_CONTROL_BIT  = 5;
    localparam int MR2_CTS_BIT    = 4;
    // command fields
    localparam int CR_TX_DIS = 3;
    localparam int CR_TX_EN  = 2;
    localparam int CR_RX_DIS = 1;
    localparam int CR_RX_EN  = 0;
    localparam logic [3:0] CMD_RESET_PTR = 4'h1;
    localparam logic [3:0] CMD_RESET_RX  = 4'h2;
    localparam logic [3:0] CMD_RESET_TX  = 4'h3;
    localparam logic [3:0] CMD_RESET_ERR = 4'h4;
    // encodings
    localparam logic [1:0] PAR_WITH      = 2'h0;
    localparam logic [1:0] PAR_FORCE     = 2'h1;
    localparam logic [1:0] PAR_NONE      = 2'h2;
    localparam logic [1:0] PAR_MULTIDROP = 2'h3;
    localparam logic [1:0] LEN_FIVE      = 2'h0;
    localparam logic [3:0] BITS_BASE     = 4'h5;
    localparam logic [1:0] MODE_NORMAL   = 2'h0;
    localparam logic [1:0] MODE_ECHO     = 2'h1;
    localparam logic [1:0] MODE_LOCAL    = 2'h2;
    localparam logic [1:0] MODE_REMOTE   = 2'h3;
    // stop length in sixteenths of a bit
    localparam int         STOP_LONG_BIT = 3;
    localparam logic [5:0] STOP_SHORT_BASE = 6'h09;
    localparam logic [5:0] STOP_LONG_BASE  = 6'h19;
    localparam logic [5:0] STOP_FIVE_EXTRA = 6'h08;

    typedef enum logic [1:0] {
        UCM_MR_ONE = 2'b01,
        UCM_MR_TWO = 2'b10
    } ucm_mr_ptr_type;

    typedef struct packed {
        logic [7:0] data;
        logic       tag_or_perr;
        logic       frame_err;
        logic       brk;
    } ucm_rx_char_type;

    typedef struct packed {
        logic [7:0] data;
        logic       tag;
        logic       tag_used;
    } ucm_tx_char_type;

    typedef struct packed {
        logic       rx_flow_ctrl;
        logic       irq_src_full;
        logic       block_err;
        logic [1:0] parity_mode;
        logic       parity_odd;
        logic [3:0] data_bits;
        logic [1:0] chan_mode;
        logic       tx_flow_ctrl;
        logic       cts_enable;
        logic [5:0] stop_sixteenths;
        logic [3:0] rx_clk_sel;
        logic [3:0] tx_clk_sel;
        logic       rx_enabled;
        logic       tx_enabled;
    } ucm_cfg_type;

    function automatic logic [5:0] stop_len(input logic [3:0] code, input logic [1:0] len);
        logic [5:0] base;
        base = code[STOP_LONG_BIT] ? STOP_LONG_BASE + {3'h0, code[2:0]}
                                   : STOP_SHORT_BASE + {3'h0, code[2:0]};
        if (!code[STOP_LONG_BIT] && len == LEN_FIVE) begin
            base = base + STOP_FIVE_EXTRA;
        end
        return base;
    endfunction
endpackage

// >>> tb/ucm_line_model.sv
// Purpose: line side station model for the two-channel control block
// Assumes: bench calls send_char; each transmit char is taken at the fifth falling edge after it shows
// Notes:   released receive lines show the inverse of the last char
`timescale 1ns/100ps
module ucm_line_model (
    // clock and reset
    input  wire logic                           i_clock,
    input  wire logic                           i_rstn,
    // transmit side of the block
    input  wire logic [1:0]                     i_tx_char_valid,
    input  wire ucm_pkg::ucm_tx_char_type [1:0] i_tx_char,
    output logic      [1:0]                     o_tx_char_taken,
    output logic      [1:0]                     o_tx_idle,
    // receive side of the block
    output logic      [1:0]                     o_rx_char_valid,
    output ucm_pkg::ucm_rx_char_type [1:0]      o_rx_char
);
    logic [2:0] wait_q [2];
    logic [7:0] got_q  [2];
    assign o_tx_idle = ~i_tx_char_valid;
    initial begin
        o_rx_char_valid = 2'b00;
        o_rx_char = '0;
        o_tx_char_taken = 2'b00;
    end
    // slow taker, so a full holding register is seen by the host
    always @(negedge i_clock) begin
        for (int c = 0; c < 2; c++) begin
            o_tx_char_taken[c] <= 1'b0;
            wait_q[c] <= (i_tx_char_valid[c] && i_rstn) ? wait_q[c] + 3'h1 : 3'h0;
            if (wait_q[c] == 3'h4) begin
                o_tx_char_taken[c] <= 1'b1;
                got_q[c] <= i_tx_char[c].data;
                wait_q[c] <= 3'h0;
            end
        end
    end
    task automatic send_char(input int ch, input logic [7:0] d, input logic tag, input logic ferr);
        @(negedge i_clock);
        o_rx_char[ch] = {d, tag, ferr, 1'b0};
        o_rx_char_valid[ch] = 1'b1;
        @(negedge i_clock);
        o_rx_char_valid[ch] = 1'b0;
        o_rx_char[ch] = ~o_rx_char[ch];
    endtask
endmodule

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the two-channel mode, command and status block
// Assumes: host port driven at falling edges with one-cycle strobes
// Notes:   line side is played by ucm_line_model
`timescale 1ns/100ps
module tb_top;
    logic       i_clock, i_rstn, i_read_strobe, i_write_strobe;
    logic [3:0] i_addr, b;
    logic [7:0] i_wdata, o_rdata, m1, m2;
    logic [1:0] i_rx_char_valid, i_tx_char_taken, i_tx_idle, o_tx_char_valid, o_receive_irq_source;
    logic [1:0] o_receiver_char_available, o_receive_buffer_full, o_transmitter_can_accept, o_transmitter_drained;
    ucm_pkg::ucm_rx_char_type [1:0] i_rx_char;
    ucm_pkg::ucm_tx_char_type [1:0] o_tx_char;
    ucm_pkg::ucm_cfg_type     [1:0] o_cfg;
    int         bad_count, n_tests, cyc;
    logic [7:0] mr1_t [4] = '{8'h40, 8'h2d, 8'h12, 8'h1f};
    logic [7:0] mr2_t [4] = '{8'h01, 8'h47, 8'h8f, 8'hc7};
    ucm_channel_ctrl ucm_channel_ctrl_i (.i_clock, .i_rstn, .i_addr, .i_read_strobe, .i_write_strobe, .i_wdata,
        .o_rdata, .i_rx_char_valid, .i_rx_char, .i_tx_char_taken, .i_tx_idle, .o_tx_char_valid, .o_tx_char,
        .o_cfg, .o_receive_irq_source, .o_receiver_char_available, .o_receive_buffer_full,
        .o_transmitter_can_accept, .o_transmitter_drained);
    ucm_line_model ucm_line_model_i (.i_clock, .i_rstn, .i_tx_char_valid(o_tx_char_valid), .i_tx_char(o_tx_char),
        .o_tx_char_taken(i_tx_char_taken), .o_tx_idle(i_tx_idle), .o_rx_char_valid(i_rx_char_valid),
        .o_rx_char(i_rx_char));
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge i_clock);
        i_addr = a;
        i_wdata = d;
        i_write_strobe = 1'b1;
        @(negedge i_clock);
        i_write_strobe = 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] mask, input logic [7:0] exp, input string what);
        @(negedge i_clock);
        i_addr = a;
        i_read_strobe = 1'b1;
        @(negedge i_clock);
        i_read_strobe = 1'b0;
        chk(what, exp, o_rdata & mask);
    endtask
    task automatic cmd(input logic [3:0] a, input logic [7:0] d);
        wr(a, d);
        repeat (3) @(negedge i_clock);
    endtask
    task automatic end_of_test;
        if (bad_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        {i_rstn, i_read_strobe, i_write_strobe, i_addr, i_wdata} = '0;
        {bad_count, n_tests, cyc} = '0;
        repeat (20) @(negedge i_clock);
        i_rstn = 1'b1;
        chk("stop after reset", 8'h11, {2'h0, o_cfg[0].stop_sixteenths});
        rdc(4'h1, 8'hff, 8'h00, "status after reset");
        rdc(4'h4, 8'hff, 8'h00, "unmapped");
        for (int i = 0; i < 4; i++) begin
            b = {i[0], 3'h0};
            m1 = mr1_t[i];
            m2 = mr2_t[i];
            cmd(b | 4'h2, 8'h10);
            wr(b, m1);
            wr(b, m2);
            wr(b | 4'h1, 8'h5a + 8'(i));
            rdc(b, 8'hff, m2, "mode two");
            cmd(b | 4'h2, 8'h10);
            rdc(b, 8'hff, m1, "mode one");
            chk("irq source", {7'h0, m1[6]}, {7'h0, o_cfg[i[0]].irq_src_full});
            chk("error mode", {7'h0, m1[5]}, {7'h0, o_cfg[i[0]].block_err});
            chk("parity", {5'h0, m1[4:2]}, {5'h0, o_cfg[i[0]].parity_mode, o_cfg[i[0]].parity_odd});
            chk("char bits", 8'h05 + m1[1:0], {4'h0, o_cfg[i[0]].data_bits});
            chk("chan mode", {6'h0, m2[7:6]}, {6'h0, o_cfg[i[0]].chan_mode});
            chk("stop", m2[3] ? 8'h19 + m2[2:0] : 8'h09 + m2[2:0] + ((m1[1:0] == 2'h0) ? 8'h08 : 8'h00),
                {2'h0, o_cfg[i[0]].stop_sixteenths});
            chk("clock select", 8'h5a + 8'(i), {o_cfg[i[0]].rx_clk_sel, o_cfg[i[0]].tx_clk_sel});
        end
        wr(4'h3, 8'h41);
        chk("tx while disabled", 8'h00, {6'h0, o_tx_char_valid});
        cmd(4'h2, 8'h04);
        rdc(4'h1, 8'hff, 8'h0c, "status tx on");
        wr(4'h3, 8'h41);
        wr(4'h3, 8'h42);
        repeat (8) @(negedge i_clock);
        chk("line got", 8'h41, ucm_line_model_i.got_q[0]);
        cmd(4'ha, 8'h04);
        wr(4'hb, 8'h55);
        chk("address tag", 8'h03, {6'h0, o_tx_char[1].tag, o_tx_char[1].tag_used});
        cmd(4'ha, 8'h10);
        wr(4'h8, 8'h1b);
        repeat (8) @(negedge i_clock);
        wr(4'hb, 8'h66);
        chk("data tag", 8'h01, {6'h0, o_tx_char[1].tag, o_tx_char[1].tag_used});
        ucm_line_model_i.send_char(1, 8'h11, 1'b0, 1'b0);
        rdc(4'h9, 8'hf3, 8'h00, "data char dropped");
        ucm_line_model_i.send_char(1, 8'h22, 1'b1, 1'b0);
        chk("irq source pick", 8'h02, {6'h0, o_receive_irq_source});
        rdc(4'h9, 8'hf3, 8'h23, "address char kept");
        rdc(4'hb, 8'hff, 8'h22, "address char data");
        cmd(4'h2, 8'h10);
        wr(4'h0, 8'h32);
        cmd(4'h2, 8'h01);
        ucm_line_model_i.send_char(0, 8'h33, 1'b0, 1'b1);
        rdc(4'h3, 8'hff, 8'h33, "block char");
        rdc(4'h1, 8'hf3, 8'h40, "block error held");
        cmd(4'h2, 8'h40);
        rdc(4'h1, 8'hf3, 8'h00, "block error cleared");
        ucm_line_model_i.send_char(0, 8'h44, 1'b1, 1'b0);
        rdc(4'h1, 8'hf3, 8'h23, "block parity held");
        cmd(4'h2, 8'h20);
        rdc(4'h1, 8'hf3, 8'h00, "receiver reset clears");
        cmd(4'h2, 8'h38);
        rdc(4'h1, 8'hff, 8'h00, "tx reset and disable");
        chk("enables off", 8'h00, {6'h0, o_cfg[0].rx_enabled, o_cfg[0].tx_enabled});
        wr(4'h3, 8'h77);
        chk("tx after disable", 8'h00, {6'h0, o_tx_char_valid});
        end_of_test();
    end
endmodule
